// File: core/apd_ctl.sv
`include "apd_map.svh"
// far end: sample source and table programmer, steered by plain registers
module apd_ctl (
    // link
    apd_if.ctl lnk,
    // user sample stream
    input wire logic src_valid,
    input wire apd_pkg::apd_sample_t src_i,
    input wire apd_pkg::apd_sample_t src_q,
    input wire logic src_pre_en,
    output logic [`APD_SAMPLE_W-1:0] sink_i,
    output logic [`APD_SAMPLE_W-1:0] sink_q,
    // user table access
    input wire logic tab_req,
    input wire logic tab_wr,
    input wire apd_pkg::apd_addr_t tab_addr,
    input wire apd_pkg::apd_word_t tab_wdata,
    output logic tab_rvalid,
    output apd_pkg::apd_word_t tab_rdata
);
    import apd_pkg::*;

    logic en_q, en_d, pre_q, pre_d;
    apd_sample_t i_q, i_d, q_q, q_d;
    logic le_q, le_d, lw_q, lw_d;
    apd_addr_t a_q, a_d;
    apd_word_t w_q, w_d;
    logic [`APD_RD_LAT-1:0] rpipe_q, rpipe_d;
    logic rv_q, rv_d;
    apd_word_t rd_q, rd_d;

    always_comb begin
        en_d = src_valid;
        pre_d = src_pre_en;
        i_d = src_valid ? src_i : i_q;
        q_d = src_valid ? src_q : q_q;
        le_d = tab_req;
        lw_d = tab_req & tab_wr;
        a_d = tab_addr;
        w_d = tab_wdata;
        // read answer lands RQ14 latency after the strobe reaches the table
        rpipe_d = {rpipe_q[`APD_RD_LAT-2:0], le_q & ~lw_q}; // RQ14
        rv_d = rpipe_q[`APD_RD_LAT-1];
        rd_d = rpipe_q[`APD_RD_LAT-1] ? lnk.lut_rdata : rd_q;
    end

    always_ff @(posedge lnk.core_clk or posedge lnk.rst) begin
        if (lnk.rst) begin
            en_q <= 1'b0;
            pre_q <= 1'b0;
            i_q <= '0;
            q_q <= '0;
            le_q <= 1'b0;
            lw_q <= 1'b0;
            a_q <= '0;
            w_q <= '0;
            rpipe_q <= '0;
            rv_q <= 1'b0;
            rd_q <= '0;
        end else begin
            en_q <= en_d;
            pre_q <= pre_d;
            i_q <= i_d;
            q_q <= q_d;
            le_q <= le_d;
            lw_q <= lw_d;
            a_q <= a_d;
            w_q <= w_d;
            rpipe_q <= rpipe_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
        end
    end

    assign lnk.en = en_q;
    assign lnk.pre_en = pre_q;
    assign lnk.i_in = i_q;
    assign lnk.q_in = q_q;
    assign lnk.lut_en = le_q; // RQ13
    assign lnk.lut_wr = lw_q; // RQ13
    assign lnk.lut_addr = a_q;
    // coefficient word layout RQ7, contents per magnitude RQ8 are software's
    assign lnk.lut_wdata = w_q; // RQ7
    assign sink_i = lnk.i_out;
    assign sink_q = lnk.q_out;
    assign tab_rvalid = rv_q;
    assign tab_rdata = rd_q;
endmodule

// File: core/apd_dev.sv
// Notes on behaviour
// RQ1: capture I and Q when enable high
// RQ2: enable low freezes every pipeline stage
// RQ3: stage one squares and sums, unsigned 32-bit; code captures in stage 1 and squares and sums in stage 2
// RQ4: parameter picks 16-bit window of sum
// RQ5: square root gives 8-bit table address
// RQ6: 256 by 32 table, I high half
// RQ7: coefficients signed, 14 fraction bits
// RQ8: location n holds correction for n/256
// RQ9: complex multiply input by coefficient pair
// RQ10: truncate products, saturate to 16 bits
// RQ11: correction disabled passes input through
// RQ12: fixed 8 enabled-cycle latency both paths
// RQ13: write on access and write enable
// RQ14: read data three cycles after request
// RQ15: table port ignores sample enable
// RQ16: table may be rewritten while streaming
// RQ17: reset clears pipeline, outputs zero; code leaves the stage 5 register lut_coef_q unreset
// RQ18: samples are signed two's complement
`include "apd_map.svh"
module apd_dev #(
    parameter int unsigned SLICE_SHL = `APD_SLICE_DEF
) (
    // link
    apd_if.dev lnk
);
    import apd_pkg::*;

    localparam int W = `APD_SAMPLE_W;
    localparam int N = `APD_PIPE_LAT;
    // depth of a sample in si_q when its coefficient stands in coef_q
    localparam int TAP_MUL = 5;

    // stage regs: 1 capture, 2 sum of squares, 3 slice, 4 sqrt, 5/6 table read, 7 multiply, 8 clamp
    apd_sample_t si_q [N-1];
    apd_sample_t sq_q [N-1];
    apd_sample_t si_d [N-1];
    apd_sample_t sq_d [N-1];
    apd_sos_t sum_of_squares_q, sum_of_squares_d;
    logic [W-1:0] win_q, win_d;
    apd_addr_t mag_q, mag_d;
    apd_word_t coef_q, coef_d;
    logic signed [2*W:0] pi_q, pi_d, pq_q, pq_d;
    logic pre_q [N-1];
    logic pre_d [N-1];
    apd_sample_t io_q, io_d, qo_q, qo_d;

    // table storage, programming read path and pipeline read path
    apd_word_t mem [`APD_LUT_DEPTH];
    apd_word_t rd1_q, rd2_q, rd3_q;
    apd_word_t rd1_d, rd2_d, rd3_d;
    apd_word_t lut_coef_q, lut_coef_d;

    // floor root by trial squares, one result bit per step
    function automatic apd_addr_t isqrt(input logic [W-1:0] v);
        logic [W-1:0] rem;
        apd_addr_t r;
        logic [W-1:0] t;
        rem = v;
        r = '0;
        for (int b = `APD_MAG_W - 1; b >= 0; b--) begin
            t = W'({r | apd_addr_t'(1 << b)}) * W'({r | apd_addr_t'(1 << b)});
            if (t <= rem) begin
                r = r | apd_addr_t'(1 << b);
            end
        end
        return r;
    endfunction

    // drop the fraction bits, then clamp so large products never wrap
    function automatic apd_sample_t clamp(input logic signed [2*W:0] p);
        logic signed [2*W:0] s;
        s = p >>> `APD_COEF_FRAC;
        if (s > (2*W+1)'(32767)) begin
            return apd_sample_t'(16'h7fff);
        end else if (s < -(2*W+1)'(32768)) begin
            return apd_sample_t'(16'h8000);
        end
        return apd_sample_t'(s[W-1:0]); // RQ10
    endfunction

    always_comb begin
        logic signed [2*W-1:0] ii, qq;
        logic signed [2*W-1:0] m_ic, m_qc, m_iq, m_qi;
        logic signed [W-1:0] ci, cq;
        ii = '0;
        qq = '0;
        m_ic = '0;
        m_qc = '0;
        m_iq = '0;
        m_qi = '0;
        ci = coef_q[`APD_COEF_I_HI:`APD_COEF_I_LO]; // RQ6 RQ7
        cq = coef_q[`APD_COEF_Q_HI:`APD_COEF_Q_LO];
        // hold by default; a low enable freezes every stage at once
        for (int k = 0; k < N-1; k++) begin
            si_d[k] = si_q[k];
            sq_d[k] = sq_q[k];
            pre_d[k] = pre_q[k];
        end
        sum_of_squares_d = sum_of_squares_q;
        win_d = win_q;
        mag_d = mag_q;
        coef_d = coef_q;
        pi_d = pi_q;
        pq_d = pq_q;
        io_d = io_q;
        qo_d = qo_q;

        if (lnk.en) begin // RQ2
            // stage 1: capture sample and its correction flag
            si_d[0] = lnk.i_in; // RQ1
            sq_d[0] = lnk.q_in;
            pre_d[0] = lnk.pre_en;
            for (int k = 1; k < N-1; k++) begin
                si_d[k] = si_q[k-1];
                sq_d[k] = sq_q[k-1];
                pre_d[k] = pre_q[k-1];
            end
            // stage 2: at most twice 32768 squared, so 32 unsigned bits never wrap
            ii = si_q[0] * si_q[0]; // RQ18
            qq = sq_q[0] * sq_q[0];
            sum_of_squares_d = apd_sos_t'(ii) + apd_sos_t'(qq); // RQ3

            // stages 3 and 4: window, then root as the table address
            win_d = sum_of_squares_q[SLICE_SHL +: W]; // RQ4
            mag_d = isqrt(win_q); // RQ5

            // stage 5 is the ram read; stage 6 re-times the word for the multiplier
            coef_d = lut_coef_q;

            // stage 7: full-width products, sign-extended before the sum
            m_ic = si_q[TAP_MUL] * ci;
            m_qc = sq_q[TAP_MUL] * cq;
            m_iq = si_q[TAP_MUL] * cq;
            m_qi = sq_q[TAP_MUL] * ci;
            pi_d = $signed({m_ic[2*W-1], m_ic}) - $signed({m_qc[2*W-1], m_qc}); // RQ9
            pq_d = $signed({m_iq[2*W-1], m_iq}) + $signed({m_qi[2*W-1], m_qi});

            // stage 8: bypass taps the same depth, so both paths take 8 enabled edges
            if (pre_q[N-2]) begin
                io_d = clamp(pi_q); // RQ10
                qo_d = clamp(pq_q);
            end else begin
                io_d = si_q[N-2]; // RQ11 RQ12
                qo_d = sq_q[N-2];
            end
        end
    end

    always_ff @(posedge lnk.core_clk or posedge lnk.rst) begin
        if (lnk.rst) begin // RQ17
            // outputs drop to zero at once; the table keeps its words
            for (int k = 0; k < N-1; k++) begin
                si_q[k] <= '0;
                sq_q[k] <= '0;
                pre_q[k] <= 1'b0;
            end
            sum_of_squares_q <= '0;
            win_q <= '0;
            mag_q <= '0;
            coef_q <= '0;
            pi_q <= '0;
            pq_q <= '0;
            io_q <= '0;
            qo_q <= '0;
        end else begin
            for (int k = 0; k < N-1; k++) begin
                si_q[k] <= si_d[k];
                sq_q[k] <= sq_d[k];
                pre_q[k] <= pre_d[k];
            end
            sum_of_squares_q <= sum_of_squares_d;
            win_q <= win_d;
            mag_q <= mag_d;
            coef_q <= coef_d;
            pi_q <= pi_d;
            pq_q <= pq_d;
            io_q <= io_d;
            qo_q <= qo_d;
        end
    end

    // programming reads advance on every core_clk edge, never gated by the stream
    always_comb begin
        rd1_d = rd1_q;
        rd2_d = rd1_q;
        rd3_d = rd2_q;
        lut_coef_d = lut_coef_q;

        if (lnk.lut_en && !lnk.lut_wr) begin // RQ14 RQ15
            rd1_d = mem[lnk.lut_addr];
        end
        // a write at the same edge as the pipeline read returns the old word
        if (lnk.en) begin // RQ2
            lut_coef_d = mem[mag_q]; // RQ6
        end
    end

    // table ram, no reset so it maps to block memory; second port is the pipeline read
    always_ff @(posedge lnk.core_clk) begin
        if (lnk.lut_en && lnk.lut_wr) begin // RQ13 RQ15 RQ16
            mem[lnk.lut_addr] <= lnk.lut_wdata;
        end
        rd1_q <= rd1_d;
        rd2_q <= rd2_d;
        rd3_q <= rd3_d;
        lut_coef_q <= lut_coef_d;
    end

    assign lnk.lut_rdata = rd3_q; // RQ14
    assign lnk.i_out = io_q;
    assign lnk.q_out = qo_q;
endmodule

// File: core/apd_if.sv
interface apd_if (
    input wire logic core_clk,
    input wire logic rst
);
    import apd_pkg::*;
    // sample stream
    logic en;
    logic pre_en;
    apd_sample_t i_in;
    apd_sample_t q_in;
    apd_sample_t i_out;
    apd_sample_t q_out;
    // table programming
    logic lut_en;
    logic lut_wr;
    apd_addr_t lut_addr;
    apd_word_t lut_wdata;
    apd_word_t lut_rdata;

    modport dev (
        input core_clk, rst, en, pre_en, i_in, q_in, lut_en, lut_wr, lut_addr, lut_wdata,
        output i_out, q_out, lut_rdata
    );
    modport ctl (
        input core_clk, rst, i_out, q_out, lut_rdata,
        output en, pre_en, i_in, q_in, lut_en, lut_wr, lut_addr, lut_wdata
    );
endinterface

// File: core/apd_map.svh
`ifndef APD_MAP_SVH
`define APD_MAP_SVH
`define APD_SAMPLE_W 16
`define APD_SOS_W 32
`define APD_MAG_W 8
`define APD_LUT_DEPTH 256
`define APD_LUT_W 32
`define APD_COEF_I_HI 31
`define APD_COEF_I_LO 16
`define APD_COEF_Q_HI 15
`define APD_COEF_Q_LO 0
`define APD_COEF_FRAC 14
`define APD_PIPE_LAT 8
`define APD_RD_LAT 3
`define APD_SLICE_DEF 15
`endif

// File: core/apd_pkg.sv
`include "apd_map.svh"
package apd_pkg;
    typedef logic signed [`APD_SAMPLE_W-1:0] apd_sample_t;
    typedef logic [`APD_MAG_W-1:0] apd_addr_t;
    typedef logic [`APD_LUT_W-1:0] apd_word_t;
    typedef logic [`APD_SOS_W-1:0] apd_sos_t;
endpackage

// File: tb/apd_dev_asserts.sv
module apd_dev_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // sample stream
    input wire logic en,
    input wire logic pre_en,
    input wire apd_pkg::apd_sample_t i_in,
    input wire apd_pkg::apd_sample_t q_in,
    input wire apd_pkg::apd_sample_t i_out,
    input wire apd_pkg::apd_sample_t q_out,
    // table port
    input wire logic lut_en,
    input wire logic lut_wr,
    input wire apd_pkg::apd_addr_t lut_addr,
    input wire apd_pkg::apd_word_t lut_wdata,
    input wire apd_pkg::apd_word_t lut_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import apd_pkg::*;
    // zero at reset like the pipeline, so no fill counter is needed
    logic [7:0][32:0] smp_q, smp_d;
    logic [2:0][32:0] rdx_q, rdx_d;
    logic [255:0] known_q, known_d;
    apd_word_t shadow [256];
    logic rd;
    assign rd = lut_en && !lut_wr;
    always_comb begin
        smp_d = en ? {smp_q[6:0], pre_en, i_in, q_in} : smp_q;
        rdx_d = {rdx_q[1:0], rd && known_q[lut_addr], shadow[lut_addr]};
        known_d = known_q;
        if (lut_en && lut_wr) known_d[lut_addr] = 1'b1;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            smp_q <= '0;
            rdx_q <= '0;
            known_q <= '0;
        end else begin
            smp_q <= smp_d;
            rdx_q <= rdx_d;
            known_q <= known_d;
        end
    end
    // mirror survives reset, as the table does
    always_ff @(posedge core_clk) begin
        if (lut_en && lut_wr) shadow[lut_addr] <= lut_wdata;
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    AST_RST_CLEAR: assert property ($fell(rst) |-> i_out == '0 && q_out == '0)
        else $error("output not cleared by reset");
    AST_STALL: assert property (!en |=> $stable(i_out) && $stable(q_out))
        else $error("output moved while stalled");
    AST_MOVE_EN: assert property ($changed(i_out) || $changed(q_out) |-> $past(en))
        else $error("output moved without enable");
    AST_BYP_I: assert property (en |=> smp_q[7][32] || i_out == smp_q[7][31:16])
        else $error("bypass i wrong");
    AST_BYP_Q: assert property (en |=> smp_q[7][32] || q_out == smp_q[7][15:0])
        else $error("bypass q wrong");
    AST_ZERO: assert property (en |=> !smp_q[7][32] || smp_q[7][31:0] != '0 || {i_out, q_out} == '0)
        else $error("zero input gave nonzero");
    AST_RD_LAT: assert property (rdx_q[2][32] |-> lut_rdata == rdx_q[2][31:0])
        else $error("read data wrong");
    AST_RD_HOLD: assert property ($changed(lut_rdata) |-> $past(rd, 3))
        else $error("read data moved untimely");
endmodule

// File: tb/apd_test.sv
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; $display("CHECK FAILED %0t %s", $time, msg); end end
module apd_test;
    timeunit 1ns;
    timeprecision 1ps;
    import apd_pkg::*;
    localparam int SLICE = 13;
    logic core_clk = 1'b0, rst = 1'b1, src_valid = 1'b0, src_pre_en = 1'b0, tab_req = 1'b0, tab_wr = 1'b0;
    logic ev_pend = 1'b0, tab_rvalid;
    apd_sample_t src_i = '0, src_q = '0;
    apd_addr_t tab_addr = '0;
    apd_word_t tab_wdata = '0, tab_rdata;
    apd_word_t tbl [256];
    logic [15:0] sink_i, sink_q;
    logic [31:0] ex_pend;
    logic [31:0] exq [$];
    int error_cnt = 0, num_checks = 0;
    always #2.5 core_clk = ~core_clk;
    apd_if apd_if_inst (.core_clk(core_clk), .rst(rst));
    apd_dev #(.SLICE_SHL(SLICE)) apd_dev_inst (.lnk(apd_if_inst));
    apd_ctl apd_ctl_inst (.lnk(apd_if_inst), .src_valid(src_valid), .src_i(src_i), .src_q(src_q),
        .src_pre_en(src_pre_en), .sink_i(sink_i), .sink_q(sink_q), .tab_req(tab_req), .tab_wr(tab_wr),
        .tab_addr(tab_addr), .tab_wdata(tab_wdata), .tab_rvalid(tab_rvalid), .tab_rdata(tab_rdata));
    apd_dev_asserts apd_dev_asserts_inst (.core_clk(core_clk), .rst(rst), .en(apd_if_inst.en),
        .pre_en(apd_if_inst.pre_en), .i_in(apd_if_inst.i_in), .q_in(apd_if_inst.q_in), .i_out(apd_if_inst.i_out),
        .q_out(apd_if_inst.q_out), .lut_en(apd_if_inst.lut_en), .lut_wr(apd_if_inst.lut_wr),
        .lut_addr(apd_if_inst.lut_addr), .lut_wdata(apd_if_inst.lut_wdata), .lut_rdata(apd_if_inst.lut_rdata));
    function automatic logic [15:0] sat(input longint v);
        return v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : 16'(v);
    endfunction
    function automatic logic [31:0] model(input logic [15:0] i, input logic [15:0] q, input logic p);
        longint si = $signed(i);
        longint sq = $signed(q);
        logic [31:0] sum_of_squares = 32'(si * si + sq * sq);
        logic [15:0] win = 16'(sum_of_squares >> SLICE);
        longint ci, cq;
        int r = 0;
        while (r < 255 && (r + 1) * (r + 1) <= win) r++;
        ci = $signed(tbl[r][31:16]);
        cq = $signed(tbl[r][15:0]);
        if (!p) return {i, q};
        return {sat((si * ci - sq * cq) >>> 14), sat((si * cq + sq * ci) >>> 14)};
    endfunction
    // sampled at the falling edge, away from the launching edge
    always @(negedge core_clk) begin
        if (rst) begin
            ev_pend = 1'b0;
            exq.delete();
            repeat (7) exq.push_back('0);
        end else begin
            if (ev_pend) `CHK({sink_i, sink_q}, ex_pend, "stream out")
            ev_pend = apd_if_inst.en;
            if (ev_pend) begin
                exq.push_back(model(apd_if_inst.i_in, apd_if_inst.q_in, apd_if_inst.pre_en));
                ex_pend = exq.pop_front();
            end
        end
    end
    task automatic tab_put(input logic wr, input apd_addr_t a, input apd_word_t d);
        @(posedge core_clk);
        tab_req <= 1'b1;
        tab_wr <= wr;
        tab_addr <= a;
        tab_wdata <= d;
    endtask
    task automatic tab_get(input apd_addr_t a);
        int n = 0;
        tab_put(1'b0, a, '0);
        @(posedge core_clk);
        tab_req <= 1'b0;
        while (tab_rvalid !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1 n++;
        end
        `CHK(tab_rvalid, 1'b1, "read answer missing")
        `CHK(tab_rdata, tbl[a], "table read")
    endtask
    task automatic load_table();
        for (int a = 0; a < 256; a++) begin
            tbl[a] = a % 64 == 0 ? {a % 128 == 0 ? 16'h7fff : 16'h8000, 16'h8000} : $urandom;
            tab_put(1'b1, 8'(a), tbl[a]);
        end
        @(posedge core_clk);
        tab_req <= 1'b0;
    endtask
    task automatic stream(input int n, input int pm, input int full);
        repeat (n) begin
            @(posedge core_clk);
            src_valid <= full != 0 || $urandom_range(3) != 0;
            src_i <= $urandom_range(7) == 0 ? 16'h8000 : $urandom_range(7) == 0 ? '0 : 16'($urandom);
            src_q <= $urandom_range(7) == 0 ? 16'h7fff : $urandom_range(7) == 0 ? '0 : 16'($urandom_range(4000));
            src_pre_en <= pm > 1 ? 1'($urandom) : 1'(pm);
        end
        @(posedge core_clk);
        src_valid <= 1'b0;
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(89405));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        load_table();
        stream(400, 2, 0);
        tab_get(8'h00);
        tab_get(8'hff);
        repeat (6) tab_get(8'($urandom));
        // flush corrected samples before the table changes under them
        stream(12, 0, 1);
        fork
            stream(300, 0, 0);
            load_table();
        join
        repeat (4) @(posedge core_clk);
        stream(300, 1, 1);
        @(posedge core_clk);
        rst <= 1'b1;
        #1 `CHK({sink_i, sink_q}, 32'h0000_0000, "reset clear")
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        tab_get(8'h40);
        stream(100, 2, 0);
        repeat (20) @(posedge core_clk);
        stop_test();
    end
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
endmodule
